// >>> common/wrf_pkg.sv
// constants and types shared by the windowed register file
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package wrf_pkg;

    // storage geometry
    localparam int WRF_ENTRIES = 136;
    localparam int WRF_AW = 8;
    localparam int WRF_DW = 32;
    localparam int WRF_RW = 5;
    localparam int WRF_WPW = 3;
    localparam int WRF_WINDOWS = 8;

    localparam logic [WRF_AW-1:0] WRF_GLOBALS = 8'h08;
    localparam logic [WRF_AW-1:0] WRF_WIN_SPAN = 8'h10;
    localparam logic [WRF_AW-1:0] WRF_LOCAL_OFS = 8'h08;
    localparam logic [WRF_AW-1:0] WRF_TASK_SPAN = 8'h20;
    localparam logic [WRF_AW-1:0] WRF_INT_OFS = 8'h18;

    // register number groups (bits 4:3 of the register number)
    localparam logic [1:0] WRF_GRP_GLOBAL = 2'h0;
    localparam logic [1:0] WRF_GRP_OUT = 2'h1;
    localparam logic [1:0] WRF_GRP_LOCAL = 2'h2;
    localparam logic [1:0] WRF_GRP_IN = 2'h3;

    // handler view registers that receive the counters
    localparam logic [WRF_RW-1:0] WRF_PC_REG = 5'h11;
    localparam logic [WRF_RW-1:0] WRF_NPC_REG = 5'h12;

    // control port map
    localparam int WRF_BUS_AW = 8;
    localparam logic [WRF_BUS_AW-1:0] WRF_OFS_WP = 8'h00;
    localparam logic [WRF_BUS_AW-1:0] WRF_OFS_WIM = 8'h04;
    localparam logic [WRF_BUS_AW-1:0] WRF_OFS_CTRL = 8'h08;
    localparam logic [WRF_BUS_AW-1:0] WRF_OFS_STAT = 8'h0c;

    // field positions
    localparam int WRF_CTRL_TASK_BIT = 0;
    localparam int WRF_STAT_SUPER_BIT = 0;
    localparam int WRF_STAT_BUSY_BIT = 1;

    // reset values
    localparam logic [WRF_WPW-1:0] WRF_WP_RST = 3'h0;
    localparam logic [WRF_WINDOWS-1:0] WRF_WIM_RST = 8'h00;

    // worst case figures in cycles
    localparam int WRF_ENTRY_MAX_CYC = 14;
    localparam int WRF_RETURN_MAX_CYC = 2;

    typedef enum logic [2:0] {
        WRF_ST_IDLE = 3'b000,
        WRF_ST_SAVE_PC = 3'b001,
        WRF_ST_SAVE_NPC = 3'b010,
        WRF_ST_DONE = 3'b011,
        WRF_ST_RET_RD = 3'b100,
        WRF_ST_RESUME = 3'b101
    } wrf_state_t;

    // register number plus pointer to physical entry
    function automatic logic [WRF_AW-1:0] wrf_map(
        input logic task_mode,
        input logic [WRF_WPW-1:0] wp,
        input logic [WRF_RW-1:0] r
    );
        logic [WRF_AW-1:0] base;
        logic [WRF_AW-1:0] sub;
        logic [WRF_WPW-1:0] prev;
        base = 8'h00;
        sub = {5'h00, r[2:0]};
        prev = wp - 3'h1;
        if (r[4:3] == WRF_GRP_GLOBAL)
        begin
            return {3'h0, r};
        end
        if (task_mode)
        begin
            base = WRF_GLOBALS + WRF_TASK_SPAN * {6'h00, wp[2:1]};
            if (wp[0] && r[4:3] == WRF_GRP_LOCAL)
            begin
                return base + WRF_INT_OFS + sub;
            end
            return base + {3'h0, r} - WRF_GLOBALS;
        end
        case (r[4:3])
            WRF_GRP_OUT: base = WRF_GLOBALS + WRF_WIN_SPAN * {5'h00, wp};
            WRF_GRP_LOCAL: base = WRF_GLOBALS + WRF_WIN_SPAN * {5'h00, wp} + WRF_LOCAL_OFS;
            default: base = WRF_GLOBALS + WRF_WIN_SPAN * {5'h00, prev};
        endcase
        return base + sub;
    endfunction

endpackage

// >>> hdl/wrf_store.sv
// storage array: one write port, two registered read ports
module wrf_store
    import wrf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [WRF_AW-1:0] waddr,
    input wire logic [WRF_DW-1:0] wdata,
    input wire logic [WRF_AW-1:0] raddr_a,
    input wire logic [WRF_AW-1:0] raddr_b,
    output logic [WRF_DW-1:0] rdata_a,
    output logic [WRF_DW-1:0] rdata_b
);

    logic [WRF_DW-1:0] mem [WRF_ENTRIES];
    logic [WRF_DW-1:0] next_rdata_a;
    logic [WRF_DW-1:0] next_rdata_b;

    always_comb
    begin
        next_rdata_a = mem[raddr_a];
        next_rdata_b = mem[raddr_b];
    end

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_a <= '0;
            rdata_b <= '0;
        end
        else
        begin
            rdata_a <= next_rdata_a;
            rdata_b <= next_rdata_b;
        end
    end

endmodule // wrf_store

// >>> hdl/wrf_top.sv
// windowed register file with window and task set models
module wrf_top
    import wrf_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    // pipeline access
    input wire logic [WRF_RW-1:0] rd_reg_a,
    input wire logic [WRF_RW-1:0] rd_reg_b,
    output logic [WRF_DW-1:0] rd_data_a,
    output logic [WRF_DW-1:0] rd_data_b,
    input wire logic wr_en,
    input wire logic [WRF_RW-1:0] wr_reg,
    input wire logic [WRF_DW-1:0] wr_data,
    // window rotation
    input wire logic save_req,
    input wire logic restore_req,
    output logic window_fault,
    // interrupt entry and return
    input wire logic irq_take,
    input wire logic [WRF_DW-1:0] trap_pc,
    input wire logic [WRF_DW-1:0] trap_npc,
    output logic handler_ready,
    input wire logic trap_return,
    output logic resume_valid,
    output logic [WRF_DW-1:0] resume_pc,
    output logic [WRF_DW-1:0] resume_npc,
    output logic supervisor,
    output logic busy,
    // control port
    input wire logic [WRF_BUS_AW-1:0] bus_addr,
    input wire logic [WRF_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [WRF_DW-1:0] bus_rdata
);

    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    logic [WRF_WPW-1:0] window_pointer;
    logic [WRF_WPW-1:0] next_window_pointer;
    logic [WRF_WINDOWS-1:0] window_invalid_mask;
    logic [WRF_WINDOWS-1:0] next_window_invalid_mask;
    logic task_mode;
    logic next_task_mode;
    logic next_supervisor;
    logic prev_super;
    logic next_prev_super;
    logic next_window_fault;
    logic [WRF_DW-1:0] next_bus_rdata;
    logic [WRF_DW-1:0] held_pc;
    logic [WRF_DW-1:0] next_held_pc;
    logic [WRF_DW-1:0] held_npc;
    logic [WRF_DW-1:0] next_held_npc;
    wrf_state_t state;
    wrf_state_t next_state;

    logic idle;
    logic take_irq;
    logic take_ret;
    logic [WRF_WPW-1:0] wp_up;
    logic [WRF_WPW-1:0] wp_down;
    logic [WRF_AW-1:0] phys_a;
    logic [WRF_AW-1:0] phys_b;
    logic mem_we;
    logic [WRF_AW-1:0] mem_waddr;
    logic [WRF_DW-1:0] mem_wdata;

    assign idle = (state == WRF_ST_IDLE);
    assign take_irq = idle && irq_take;
    assign take_ret = idle && !irq_take && trap_return && supervisor;
    assign wp_up = window_pointer + 3'h1;
    assign wp_down = window_pointer - 3'h1;
    assign busy = !idle;
    assign handler_ready = (state == WRF_ST_DONE);
    assign resume_valid = (state == WRF_ST_RESUME);
    assign resume_pc = rd_data_a;
    assign resume_npc = rd_data_b;

    //--------------------------------------------------------------------------
    // address resolution and storage
    //--------------------------------------------------------------------------
    always_comb
    begin
        phys_a = wrf_map(task_mode, window_pointer, rd_reg_a);
        phys_b = wrf_map(task_mode, window_pointer, rd_reg_b);
        mem_we = idle && wr_en;
        mem_waddr = wrf_map(task_mode, window_pointer, wr_reg);
        mem_wdata = wr_data;
        case (state)
            WRF_ST_SAVE_PC:
            begin
                mem_we = 1'b1;
                mem_waddr = wrf_map(task_mode, window_pointer, WRF_PC_REG);
                mem_wdata = held_pc;
            end
            WRF_ST_SAVE_NPC:
            begin
                mem_we = 1'b1;
                mem_waddr = wrf_map(task_mode, window_pointer, WRF_NPC_REG);
                mem_wdata = held_npc;
            end
            WRF_ST_RET_RD:
            begin
                mem_we = 1'b0;
                phys_a = wrf_map(task_mode, window_pointer, WRF_PC_REG);
                phys_b = wrf_map(task_mode, window_pointer, WRF_NPC_REG);
            end
            default:
            begin
            end
        endcase
    end

    wrf_store u_store (
        .clk(clk),
        .resetn(resetn),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(phys_a),
        .raddr_b(phys_b),
        .rdata_a(rd_data_a),
        .rdata_b(rd_data_b)
    );

    //--------------------------------------------------------------------------
    // trap sequencer and window pointer
    //--------------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_window_pointer = window_pointer;
        next_supervisor = supervisor;
        next_prev_super = prev_super;
        next_held_pc = held_pc;
        next_held_npc = held_npc;
        next_window_fault = 1'b0;
        case (state)
            WRF_ST_IDLE:
            begin
                if (take_irq)
                begin
                    next_state = WRF_ST_SAVE_PC;
                    next_supervisor = 1'b1;
                    next_prev_super = supervisor;
                    next_held_pc = trap_pc;
                    next_held_npc = trap_npc;
                    if (task_mode)
                    begin
                        next_window_pointer = {window_pointer[2:1], 1'b1};
                    end
                    else
                    begin
                        next_window_pointer = wp_up;
                    end
                end
                else if (take_ret)
                begin
                    next_state = WRF_ST_RET_RD;
                end
                else if (bus_wr && bus_addr == WRF_OFS_WP)
                begin
                    next_window_pointer = bus_wdata[WRF_WPW-1:0];
                end
                else if (!task_mode && save_req)
                begin
                    if (window_invalid_mask[wp_up])
                    begin
                        next_window_fault = 1'b1;
                    end
                    else
                    begin
                        next_window_pointer = wp_up;
                    end
                end
                else if (!task_mode && restore_req)
                begin
                    if (window_invalid_mask[wp_down])
                    begin
                        next_window_fault = 1'b1;
                    end
                    else
                    begin
                        next_window_pointer = wp_down;
                    end
                end
            end
            WRF_ST_SAVE_PC: next_state = WRF_ST_SAVE_NPC;
            WRF_ST_SAVE_NPC: next_state = WRF_ST_DONE;
            WRF_ST_DONE: next_state = WRF_ST_IDLE;
            WRF_ST_RET_RD: next_state = WRF_ST_RESUME;
            WRF_ST_RESUME:
            begin
                next_state = WRF_ST_IDLE;
                next_supervisor = prev_super;
                if (task_mode)
                begin
                    next_window_pointer = {window_pointer[2:1], 1'b0};
                end
                else
                begin
                    next_window_pointer = wp_down;
                end
            end
            default: next_state = WRF_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= WRF_ST_IDLE;
            window_pointer <= WRF_WP_RST;
            supervisor <= 1'b1;
            prev_super <= 1'b1;
            held_pc <= '0;
            held_npc <= '0;
            window_fault <= 1'b0;
        end
        else
        begin
            state <= next_state;
            window_pointer <= next_window_pointer;
            supervisor <= next_supervisor;
            prev_super <= next_prev_super;
            held_pc <= next_held_pc;
            held_npc <= next_held_npc;
            window_fault <= next_window_fault;
        end
    end

    //--------------------------------------------------------------------------
    // control port
    //--------------------------------------------------------------------------
    always_comb
    begin
        next_window_invalid_mask = window_invalid_mask;
        next_task_mode = task_mode;
        next_bus_rdata = '0;
        if (bus_wr && bus_addr == WRF_OFS_WIM)
        begin
            next_window_invalid_mask = bus_wdata[WRF_WINDOWS-1:0];
        end
        if (bus_wr && bus_addr == WRF_OFS_CTRL)
        begin
            next_task_mode = bus_wdata[WRF_CTRL_TASK_BIT];
        end
        if (bus_rd)
        begin
            case (bus_addr)
                WRF_OFS_WP: next_bus_rdata[WRF_WPW-1:0] = window_pointer;
                WRF_OFS_WIM: next_bus_rdata[WRF_WINDOWS-1:0] = window_invalid_mask;
                WRF_OFS_CTRL: next_bus_rdata[WRF_CTRL_TASK_BIT] = task_mode;
                WRF_OFS_STAT:
                begin
                    next_bus_rdata[WRF_STAT_SUPER_BIT] = supervisor;
                    next_bus_rdata[WRF_STAT_BUSY_BIT] = busy;
                end
                default: next_bus_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            window_invalid_mask <= WRF_WIM_RST;
            task_mode <= 1'b0;
            bus_rdata <= '0;
        end
        else
        begin
            window_invalid_mask <= next_window_invalid_mask;
            task_mode <= next_task_mode;
            bus_rdata <= next_bus_rdata;
        end
    end

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic [WRF_AW-1:0] phys_npc_chk;
    logic plain_save;
    assign phys_npc_chk = wrf_map(task_mode, window_pointer, WRF_NPC_REG);
    assign plain_save = idle && !irq_take && !trap_return && !bus_wr && !task_mode && save_req;

    sequence s_irq_in;
        take_irq;
    endsequence
    sequence s_counters_stored;
        (mem_we && mem_wdata == $past(trap_pc) && state == WRF_ST_SAVE_PC)
        ##1 (mem_we && mem_wdata == $past(trap_npc, 2) && mem_waddr == phys_npc_chk);
    endsequence

    AST_SAVE_ADVANCE: assert property (
        plain_save && !window_invalid_mask[wp_up] |=> window_pointer == $past(wp_up))
        else $error("save did not advance the window");
    AST_RESTORE_BACK: assert property (
        idle && !irq_take && !trap_return && !bus_wr && !task_mode && !save_req
        && restore_req && !window_invalid_mask[wp_down]
        |=> window_pointer == $past(window_pointer) - 3'h1)
        else $error("restore did not step back");
    AST_WP_WRITE: assert property (
        idle && !irq_take && !trap_return && bus_wr && bus_addr == WRF_OFS_WP
        |=> window_pointer == $past(bus_wdata[WRF_WPW-1:0]))
        else $error("window pointer write lost");
    AST_IRQ_SET: assert property (
        take_irq && task_mode |=> window_pointer[0] && supervisor
        && window_pointer[2:1] == $past(window_pointer[2:1]))
        else $error("interrupt set not selected");
    AST_PC_STORE: assert property (
        s_irq_in |=> s_counters_stored)
        else $error("counters not stored on interrupt");
    AST_ENTRY_TIME: assert property (
        take_irq |-> ##[1:14] handler_ready)
        else $error("interrupt entry too slow");
    AST_RETURN_TIME: assert property (
        take_ret |-> ##2 resume_valid ##1 (supervisor == $past(prev_super)))
        else $error("trap return not done in two cycles");
    AST_GLOBALS: assert property (
        rd_reg_a[4:3] == WRF_GRP_GLOBAL && idle |-> phys_a == {3'h0, rd_reg_a})
        else $error("global not shared");
    AST_OVERLAP: assert property (
        idle && !task_mode && rd_reg_a[4:3] == WRF_GRP_IN
        |-> phys_a == wrf_map(1'b0, wp_down, {WRF_GRP_OUT, rd_reg_a[2:0]}))
        else $error("incoming group not shared with neighbour");
    AST_MASK_READ: assert property (
        bus_rd && bus_addr == WRF_OFS_WIM
        |=> bus_rdata[WRF_WINDOWS-1:0] == $past(window_invalid_mask))
        else $error("mask read wrong");

endmodule // wrf_top

// >>> verification/wrf_top_tb.sv
// self-checking bench for the windowed register file
`define CHK(nm, ex, got) \
    begin \
        checked++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("BAD %s expected %h seen %h", nm, ex, got); \
        end \
    end

module wrf_top_tb import wrf_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    //--------------------------------------------------------------------------
    // signals
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] wpw;
        logic [4:0] rw;
        logic [31:0] d;
        logic [2:0] wpr;
        logic [4:0] rr;
        logic [31:0] ex;
    } wrf_row_t;

    int errors = 0;
    int checked = 0;
    int n;
    logic clk;
    logic resetn;
    logic [WRF_RW-1:0] rd_reg_a, rd_reg_b, wr_reg;
    logic [WRF_DW-1:0] rd_data_a, rd_data_b, wr_data, trap_pc, trap_npc;
    logic [WRF_DW-1:0] resume_pc, resume_npc, bus_wdata, bus_rdata, v;
    logic wr_en, save_req, restore_req, window_fault, irq_take, handler_ready;
    logic trap_return, resume_valid, supervisor, busy, bus_wr, bus_rd, f;
    logic [WRF_BUS_AW-1:0] bus_addr;
    logic [63:0] vv;
    wrf_row_t rows [6];

    wrf_top u_dut (
        .clk(clk), .resetn(resetn), .rd_reg_a(rd_reg_a), .rd_reg_b(rd_reg_b),
        .rd_data_a(rd_data_a), .rd_data_b(rd_data_b), .wr_en(wr_en), .wr_reg(wr_reg),
        .wr_data(wr_data), .save_req(save_req), .restore_req(restore_req),
        .window_fault(window_fault), .irq_take(irq_take), .trap_pc(trap_pc),
        .trap_npc(trap_npc), .handler_ready(handler_ready), .trap_return(trap_return),
        .resume_valid(resume_valid), .resume_pc(resume_pc), .resume_npc(resume_npc),
        .supervisor(supervisor), .busy(busy), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
    );

    //--------------------------------------------------------------------------
    // clock and watchdog
    //--------------------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        repeat (3000) @(posedge clk);
        errors++;
        close_out();
    end

    //--------------------------------------------------------------------------
    // drivers
    //--------------------------------------------------------------------------
    task automatic wr_bus(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd_bus(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic wr_r(input logic [4:0] r, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_reg <= r;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // both read ports look at the same number
    task automatic rd_r(input logic [4:0] r, output logic [63:0] d);
        @(posedge clk);
        rd_reg_a <= r;
        rd_reg_b <= r;
        @(posedge clk);
        #1;
        d = {rd_data_a, rd_data_b};
    endtask

    task automatic rot(input logic fwd, output logic flt);
        @(posedge clk);
        save_req <= fwd;
        restore_req <= ~fwd;
        @(posedge clk);
        save_req <= 1'b0;
        restore_req <= 1'b0;
        #1;
        flt = window_fault;
    endtask

    // one pulse of interrupt or return, then count cycles to its answer
    task automatic evt(input logic is_irq, output int cnt);
        @(posedge clk);
        irq_take <= is_irq;
        trap_return <= ~is_irq;
        @(posedge clk);
        irq_take <= 1'b0;
        trap_return <= 1'b0;
        cnt = 1;
        #1;
        while (((is_irq ? handler_ready : resume_valid) !== 1'b1) && cnt < 20)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask

    task automatic close_out();
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        {wr_en, save_req, restore_req, irq_take, trap_return, bus_wr, bus_rd} = 7'h00;
        rd_reg_a = 5'h00;
        rd_reg_b = 5'h00;
        wr_reg = 5'h00;
        wr_data = 32'h0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        trap_pc = 32'h0000_1000;
        trap_npc = 32'h0000_1004;
        // write in one window, read in the same or another
        rows[0] = '{3'h0, 5'h01, 32'h0000_0a01, 3'h5, 5'h01, 32'h0000_0a01};
        rows[1] = '{3'h0, 5'h08, 32'h0000_0b08, 3'h1, 5'h18, 32'h0000_0b08};
        rows[2] = '{3'h7, 5'h0f, 32'h0000_0c0f, 3'h0, 5'h1f, 32'h0000_0c0f};
        rows[3] = '{3'h3, 5'h10, 32'h0000_0d10, 3'h3, 5'h10, 32'h0000_0d10};
        rows[4] = '{3'h5, 5'h10, 32'h0000_0e10, 3'h3, 5'h10, 32'h0000_0d10};
        rows[5] = '{3'h4, 5'h1a, 32'h0000_0f1a, 3'h3, 5'h0a, 32'h0000_0f1a};
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_rst", 32'h0, v)
        rd_bus(WRF_OFS_WIM, v);
        `CHK("wim_rst", 32'h0, v)
        wr_bus(WRF_OFS_STAT, 32'h0);
        rd_bus(WRF_OFS_STAT, v);
        `CHK("stat_rst", 32'h1, v)
        wr_bus(8'h10, 32'hffff_ffff);
        rd_bus(8'h10, v);
        `CHK("unmapped", 32'h0, v)
        for (int i = 0; i < 6; i++)
        begin
            wr_bus(WRF_OFS_WP, {29'h0, rows[i].wpw});
            wr_r(rows[i].rw, rows[i].d);
            wr_bus(WRF_OFS_WP, {29'h0, rows[i].wpr});
            rd_r(rows[i].rr, vv);
            `CHK("row", {rows[i].ex, rows[i].ex}, vv)
        end
        // save and restore carry values both ways
        wr_bus(WRF_OFS_WP, 32'h0);
        wr_r(5'h08, 32'h0000_1108);
        rot(1'b1, f);
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_save", 32'h1, v)
        rd_r(5'h18, vv);
        `CHK("in_after_save", {2{32'h0000_1108}}, vv)
        wr_r(5'h18, 32'h0000_2218);
        rot(1'b0, f);
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_restore", 32'h0, v)
        rd_r(5'h08, vv);
        `CHK("out_after_restore", {2{32'h0000_2218}}, vv)
        wr_bus(WRF_OFS_WP, 32'h7);
        rot(1'b1, f);
        rd_bus(WRF_OFS_WP, v);
        `CHK("wrap_up", 32'h0, v)
        rot(1'b0, f);
        rd_bus(WRF_OFS_WP, v);
        `CHK("wrap_down", 32'h7, v)
        // masked target window refuses the save and the restore
        wr_bus(WRF_OFS_WIM, 32'h1);
        rd_bus(WRF_OFS_WIM, v);
        `CHK("wim_rw", 32'h1, v)
        rot(1'b1, f);
        `CHK("fault", 1'b1, f)
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_kept", 32'h7, v)
        rot(1'b0, f);
        `CHK("no_fault", 1'b0, f)
        wr_bus(WRF_OFS_WIM, 32'h20);
        rot(1'b0, f);
        `CHK("fault_back", 1'b1, f)
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_kept_back", 32'h6, v)
        wr_bus(WRF_OFS_WIM, 32'h0);
        // task sets, interrupt entry and return
        wr_bus(WRF_OFS_CTRL, 32'h1);
        wr_bus(WRF_OFS_WP, 32'h2);
        wr_r(5'h10, 32'h0000_c110);
        wr_bus(WRF_OFS_WP, 32'h0);
        wr_r(5'h10, 32'h0000_c010);
        rd_r(5'h10, vv);
        `CHK("task_sep", {2{32'h0000_c010}}, vv)
        rot(1'b1, f);
        rd_bus(WRF_OFS_WP, v);
        `CHK("save_in_task", 32'h0, v)
        evt(1'b1, n);
        `CHK("entry_cyc", 32'h3, n)
        `CHK("entry_bound", 1'b1, n <= WRF_ENTRY_MAX_CYC)
        rd_bus(WRF_OFS_STAT, v);
        `CHK("super", 1'b1, v[WRF_STAT_SUPER_BIT])
        rd_bus(WRF_OFS_WP, v);
        `CHK("irq_set", 32'h1, v)
        rd_r(WRF_PC_REG, vv);
        `CHK("saved_pc", {2{trap_pc}}, vv)
        rd_r(WRF_NPC_REG, vv);
        `CHK("saved_npc", {2{trap_npc}}, vv)
        wr_r(5'h10, 32'h0000_cc10);
        evt(1'b0, n);
        vv = {resume_pc, resume_npc};
        `CHK("ret_cyc", 32'h2, n)
        `CHK("resume", {trap_pc, trap_npc}, vv)
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_back", 32'h0, v)
        rd_r(5'h10, vv);
        `CHK("int_regs_apart", {2{32'h0000_c010}}, vv)
        // reset again in mid-run
        wr_bus(WRF_OFS_WP, 32'h5);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_bus(WRF_OFS_CTRL, v);
        `CHK("mode_rst", 32'h0, v)
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_rst2", 32'h0, v)
        // interrupt and return in window mode step the pointer like save and restore
        evt(1'b1, n);
        `CHK("entry_cyc_win", 32'h3, n)
        rd_bus(WRF_OFS_WP, v);
        `CHK("irq_win", 32'h1, v)
        evt(1'b0, n);
        vv = {resume_pc, resume_npc};
        `CHK("resume_win", {trap_pc, trap_npc}, vv)
        rd_bus(WRF_OFS_WP, v);
        `CHK("wp_back_win", 32'h0, v)
        close_out();
    end

endmodule // wrf_top_tb
